// [core/pds_defines.svh]
// Offsets, reset values and field constants of the port data slice
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH

`define PDS_NUM_PORTS      9
`define PDS_PORT_W         8
`define PDS_ADDR_W         12

`define PDS_A_IN           12'hfd2
`define PDS_A_OUT          12'hfd3
`define PDS_B_IN           12'hfd6
`define PDS_B_OUT          12'hfd7
`define PDS_C_IN           12'hfda
`define PDS_C_OUT          12'hfdb
`define PDS_D_IN           12'hfde
`define PDS_D_OUT          12'hfdf
`define PDS_E_IN           12'hfe2
`define PDS_E_OUT          12'hfe3
`define PDS_F_IN           12'hfe6
`define PDS_F_OUT          12'hfe7
`define PDS_G_IN           12'hfea
`define PDS_G_OUT          12'hfec
`define PDS_H_IN           12'hfee
`define PDS_H_OUT          12'hfef
`define PDS_J_IN           12'hfbe
`define PDS_J_OUT          12'hfbf

`define PDS_C_INDEX        12'hf80
`define PDS_C_CONTROL      12'hf81
`define PDS_SUB_SET_ONE    8'h07
`define PDS_SUB_SET_TWO    8'h08

`define PDS_DRIVE_RESET    8'h00
`define PDS_SET_RESET      8'h00
`define PDS_INDEX_RESET    8'h00
`define PDS_PORT_C         4'h2

`endif

// [core/pds_pkg.sv]
// Types shared by the port data slice
package pds_pkg;

  typedef logic [8:0][7:0] pds_port_bus_t;

  typedef struct packed {
    logic [7:0] dir_out;
    logic [7:0] open_drain;
    logic [7:0] alt_en;
    logic [7:0] alt_val;
    logic [7:0] alt_oe;
  } pds_port_cfg_t;

  typedef pds_port_cfg_t [8:0] pds_cfg_bus_t;

  typedef logic [3:0][7:0] pds_alt_c_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } pds_drive_t;

endpackage

// [core/pds_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
module pds_sync
  import pds_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pds_sync_state_t;

  pds_sync_state_t st_reg;
  pds_sync_state_t st_next;

  always_comb
  begin
    st_next        = st_reg;
    st_next.stage1 = i_async;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_sync = st_reg.stage2;

endmodule

// [core/pds_pin_drv.sv]
// Output driver of one eight-pin port
module pds_pin_drv
  import pds_pkg::*;
#(
  parameter bit PRESENT = 1'b1
)
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_rstn,
  input  wire logic [7:0]    i_drive,
  input  wire pds_port_cfg_t i_cfg,
  output pds_drive_t         o_drv
);

  pds_drive_t st_reg;
  pds_drive_t st_next;

  always_comb
  begin
    st_next = '0;
    for (int b = 0; b < 8; b++)
    begin
      if (!PRESENT)
      begin
        st_next.pin_out[b] = 1'b0;
        st_next.pin_oe[b]  = 1'b0;
      end
      else if (i_cfg.alt_en[b])
      begin
        // Peripheral owns the pin; the drive register is ignored
        st_next.pin_out[b] = i_cfg.alt_val[b];
        st_next.pin_oe[b]  = i_cfg.alt_oe[b] &
                             !(i_cfg.open_drain[b] & i_cfg.alt_val[b]);
      end
      else if (i_cfg.dir_out[b])
      begin
        st_next.pin_out[b] = i_drive[b];
        // Open drain releases the pin instead of pulling it high
        st_next.pin_oe[b]  = !(i_cfg.open_drain[b] & i_drive[b]);
      end
      else
      begin
        st_next.pin_out[b] = i_drive[b];
        st_next.pin_oe[b]  = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_drv = st_reg;

endmodule

// [core/pds_top.sv]
// Port input sample, output drive and port C alternate set registers
`include "pds_defines.svh"

module pds_top
  import pds_pkg::*;
#(
  parameter logic [8:0] PORT_PRESENT = 9'h1ff
)
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire logic [11:0]       i_addr,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata,
  output logic                   o_rvalid,
  input  wire pds_port_bus_t     i_pin_in,
  input  wire pds_cfg_bus_t      i_cfg,
  input  wire pds_alt_c_t        i_alt_c_entry,
  output pds_port_bus_t          o_pin_out,
  output pds_port_bus_t          o_pin_oe,
  output logic      [7:0]        o_alt_c_set_one,
  output logic      [7:0]        o_alt_c_set_two
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pds_port_bus_t drive;
    logic [7:0]    sub_index;
    logic [7:0]    set_one;
    logic [7:0]    set_two;
    logic [7:0]    rdata;
    logic          rvalid;
  } pds_top_state_t;

  pds_top_state_t st_reg;
  pds_top_state_t st_next;
  pds_port_bus_t  pin_sync;
  pds_cfg_bus_t   cfg_eff;
  pds_drive_t     drv [9];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  typedef struct packed {
    logic       hit;
    logic       is_out;
    logic [3:0] port;
  } pds_dec_t;

  function automatic pds_dec_t decode(input logic [11:0] a);
    pds_dec_t d;
    d = '0;
    d.hit = 1'b1;
    case (a)
      `PDS_A_IN:  d.port = 4'h0;
      `PDS_A_OUT: {d.is_out, d.port} = {1'b1, 4'h0};
      `PDS_B_IN:  d.port = 4'h1;
      `PDS_B_OUT: {d.is_out, d.port} = {1'b1, 4'h1};
      `PDS_C_IN:  d.port = 4'h2;
      `PDS_C_OUT: {d.is_out, d.port} = {1'b1, 4'h2};
      `PDS_D_IN:  d.port = 4'h3;
      `PDS_D_OUT: {d.is_out, d.port} = {1'b1, 4'h3};
      `PDS_E_IN:  d.port = 4'h4;
      `PDS_E_OUT: {d.is_out, d.port} = {1'b1, 4'h4};
      `PDS_F_IN:  d.port = 4'h5;
      `PDS_F_OUT: {d.is_out, d.port} = {1'b1, 4'h5};
      `PDS_G_IN:  d.port = 4'h6;
      `PDS_G_OUT: {d.is_out, d.port} = {1'b1, 4'h6};
      `PDS_H_IN:  d.port = 4'h7;
      `PDS_H_OUT: {d.is_out, d.port} = {1'b1, 4'h7};
      `PDS_J_IN:  d.port = 4'h8;
      `PDS_J_OUT: {d.is_out, d.port} = {1'b1, 4'h8};
      default:    d.hit = 1'b0;
    endcase
    return d;
  endfunction

  pds_dec_t dec;
  assign dec = decode(i_addr);

  logic wr_index;
  logic wr_ctl;
  logic rd_ctl;
  assign wr_index = i_wr && (i_addr == `PDS_C_INDEX);
  assign wr_ctl   = i_wr && (i_addr == `PDS_C_CONTROL);
  assign rd_ctl   = i_rd && (i_addr == `PDS_C_CONTROL);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Pins change at any time; reading them raw could return a
  // metastable value to software
  pds_sync #(
    .WIDTH (72)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_pin_in),
    .o_sync    (pin_sync)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = i_rd;
    st_next.rdata  = 8'h00;
    if (wr_index)
      st_next.sub_index = i_wdata;
    if (wr_ctl && st_reg.sub_index == `PDS_SUB_SET_TWO)
      st_next.set_two = i_wdata;
    if (wr_ctl && st_reg.sub_index == `PDS_SUB_SET_ONE)
      st_next.set_one = i_wdata;
    // Writes to sample addresses fall through untouched
    if (i_wr && dec.hit && dec.is_out)
      st_next.drive[dec.port] = i_wdata;
    if (i_rd)
    begin
      if (dec.hit && dec.is_out)
        st_next.rdata = st_reg.drive[dec.port];
      else if (dec.hit && PORT_PRESENT[dec.port])
        st_next.rdata = pin_sync[dec.port];
      else if (dec.hit)
        st_next.rdata = 8'h00;
      else if (i_addr == `PDS_C_INDEX)
        st_next.rdata = st_reg.sub_index;
      else if (rd_ctl && st_reg.sub_index == `PDS_SUB_SET_TWO)
        st_next.rdata = st_reg.set_two;
      else if (rd_ctl && st_reg.sub_index == `PDS_SUB_SET_ONE)
        st_next.rdata = st_reg.set_one;
      else
        st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg.drive     <= {9{`PDS_DRIVE_RESET}};
      st_reg.sub_index <= `PDS_INDEX_RESET;
      st_reg.set_one   <= `PDS_SET_RESET;
      st_reg.set_two   <= `PDS_SET_RESET;
      st_reg.rdata     <= 8'h00;
      st_reg.rvalid    <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  assign o_rdata         = st_reg.rdata;
  assign o_rvalid        = st_reg.rvalid;
  assign o_alt_c_set_one = st_reg.set_one;
  assign o_alt_c_set_two = st_reg.set_two;

  // ****************************************************************
  // Alternate selection and pin drivers
  // ****************************************************************
  always_comb
  begin
    cfg_eff = i_cfg;
    for (int b = 0; b < 8; b++)
      cfg_eff[2].alt_val[b] =
        i_alt_c_entry[{st_reg.set_two[b], st_reg.set_one[b]}][b];
  end

  for (genvar p = 0; p < 9; p++)
  begin : g_port
    pds_pin_drv #(
      .PRESENT (PORT_PRESENT[p])
    ) u_drv (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_drive   (st_reg.drive[p]),
      .i_cfg     (cfg_eff[p]),
      .o_drv     (drv[p])
    );
    assign o_pin_out[p] = drv[p].pin_out;
    assign o_pin_oe[p]  = drv[p].pin_oe;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_index_write:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_index |=> st_reg.sub_index == $past(i_wdata))
  else $error("Index register did not take written value");

  a_set_two_write:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_index && i_wdata == `PDS_SUB_SET_TWO ##1 !wr_index ##1 wr_ctl
    |=> o_alt_c_set_two == $past(i_wdata))
  else $error("Set two not written through index 08h");

  a_set_one_write:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_ctl && st_reg.sub_index == 8'h07
    |=> o_alt_c_set_one == $past(i_wdata) && $stable(o_alt_c_set_two))
  else $error("Set one write wrong or disturbed set two");

  a_sample_readonly:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_wr && dec.hit && !dec.is_out |=> $stable(st_reg.drive))
  else $error("Write to sample address changed drive state");

  a_sample_read:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_rd && i_addr == `PDS_A_IN && PORT_PRESENT[0]
    |=> o_rvalid && o_rdata == $past(pin_sync[0]))
  else $error("Port A sample read returned wrong level");

  a_absent_zero:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_rd && dec.hit && !dec.is_out && !PORT_PRESENT[dec.port]
    |=> o_rdata == 8'h00)
  else $error("Absent port sample read not zero");

  a_sync_stages:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $past(i_rstn) && $past(i_rstn, 2) |-> pin_sync == $past(i_pin_in, 2))
  else $error("Pin sample not two stages behind pin");

  a_drive_write:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_wr && i_addr == `PDS_G_OUT && PORT_PRESENT[6]
    |=> st_reg.drive[6] == $past(i_wdata) ##1
        o_pin_out[6][0] == ($past(i_cfg[6].alt_en[0]) ?
        $past(i_cfg[6].alt_val[0]) : st_reg.drive[6][0]))
  else $error("Port G drive register or pin mismatch");

  a_drive_level:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_cfg[0].dir_out[0] && !i_cfg[0].alt_en[0] && !i_cfg[0].open_drain[0]
    && PORT_PRESENT[0]
    |=> o_pin_oe[0][0] && o_pin_out[0][0] == $past(st_reg.drive[0][0]))
  else $error("Output pin not driven to its drive bit");

  a_od_release:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_cfg[1].dir_out[3] && !i_cfg[1].alt_en[3] && i_cfg[1].open_drain[3]
    && st_reg.drive[1][3]
    |=> !o_pin_oe[1][3])
  else $error("Open-drain pin driven high");

  a_input_quiet:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !i_cfg[3].dir_out[5] && !i_cfg[3].alt_en[5] |=> !o_pin_oe[3][5])
  else $error("Input pin driven");

  a_alt_gate:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_cfg[2].alt_en[4] && PORT_PRESENT[2] && i_cfg[2].alt_oe[4]
    && !i_cfg[2].open_drain[4]
    |=> o_pin_oe[2][4] && o_pin_out[2][4] == $past(cfg_eff[2].alt_val[4]))
  else $error("Alternate function not routed to port C pin");

  a_read_valid:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_rd |=> o_rvalid)
  else $error("Read not answered with valid flag");

  a_rdata_idle:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !i_rd |=> !o_rvalid && o_rdata == 8'h00)
  else $error("Read data or valid flag stood too long");

  a_set_two_read:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rd_ctl && st_reg.sub_index == `PDS_SUB_SET_TWO
    |=> o_rdata == $past(o_alt_c_set_two))
  else $error("Set two read through control returned wrong value");

  a_drive_read:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_rd && dec.hit && dec.is_out
    |=> o_rdata == $past(st_reg.drive[dec.port]))
  else $error("Drive register read returned wrong value");

  a_index_hold:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_index
    |=> $stable(o_alt_c_set_one) && $stable(o_alt_c_set_two))
  else $error("Index write disturbed a set register");

  a_ctl_other_wr:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_ctl && st_reg.sub_index != `PDS_SUB_SET_ONE
    && st_reg.sub_index != `PDS_SUB_SET_TWO
    |=> $stable(o_alt_c_set_one) && $stable(o_alt_c_set_two))
  else $error("Control write with other index changed a set");

  a_ctl_other_rd:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rd_ctl && st_reg.sub_index != `PDS_SUB_SET_ONE
    && st_reg.sub_index != `PDS_SUB_SET_TWO
    |=> o_rdata == 8'h00)
  else $error("Control read with other index not zero");

  a_unmapped_wr:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_wr && !dec.hit && !wr_index && !wr_ctl
    |=> $stable(st_reg.drive) && $stable(st_reg.sub_index)
        && $stable(o_alt_c_set_one) && $stable(o_alt_c_set_two))
  else $error("Unmapped write changed register state");

  a_alt_select:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_cfg[2].alt_en[7] && PORT_PRESENT[2]
    |=> o_pin_out[2][7] == $past(i_alt_c_entry[{o_alt_c_set_two[7],
        o_alt_c_set_one[7]}][7]))
  else $error("Port C pin 7 carries wrong alternate entry");

  a_od_low:
  assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_cfg[4].dir_out[1] && !i_cfg[4].alt_en[1] && i_cfg[4].open_drain[1]
    && !st_reg.drive[4][1] && PORT_PRESENT[4]
    |=> o_pin_oe[4][1] && !o_pin_out[4][1])
  else $error("Open-drain pin not pulled low for cleared bit");

  for (genvar q = 0; q < 9; q++)
  begin : g_absent_chk
    a_absent_quiet:
    assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      !PORT_PRESENT[q] |-> o_pin_oe[q] == 8'h00)
    else $error("Absent port drives a pin");
  end

endmodule

// [tb/tb_pds_top.sv]
// Self-checking bench for the port data slice
`include "pds_defines.svh"

module tb
  import pds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Port H is left out of the fitted package
  localparam logic [8:0] PRES = 9'h17f;
  localparam logic [11:0] IN_A [9] = '{`PDS_A_IN, `PDS_B_IN, `PDS_C_IN,
    `PDS_D_IN, `PDS_E_IN, `PDS_F_IN, `PDS_G_IN, `PDS_H_IN, `PDS_J_IN};
  localparam logic [11:0] OUT_A [9] = '{`PDS_A_OUT, `PDS_B_OUT, `PDS_C_OUT,
    `PDS_D_OUT, `PDS_E_OUT, `PDS_F_OUT, `PDS_G_OUT, `PDS_H_OUT, `PDS_J_OUT};

  logic          i_sys_clk;
  logic          i_rstn;
  logic [11:0]   i_addr;
  logic          i_wr;
  logic          i_rd;
  logic [7:0]    i_wdata;
  logic [7:0]    o_rdata;
  logic          o_rvalid;
  logic [71:0]   pin_bits;
  logic [359:0]  cfg_bits;
  logic [31:0]   alt_bits;
  pds_cfg_bus_t  cfg_v;
  pds_alt_c_t    alt_v;
  pds_port_bus_t o_pin_out;
  pds_port_bus_t o_pin_oe;
  logic [7:0]    o_alt_c_set_one;
  logic [7:0]    o_alt_c_set_two;
  logic [15:0]   lfsr;
  int            miscompares;
  int            checked;
  int            cycles;

  assign cfg_v = pds_cfg_bus_t'(cfg_bits);
  assign alt_v = pds_alt_c_t'(alt_bits);

  pds_top #(
    .PORT_PRESENT    (PRES)
  ) uut (
    .i_sys_clk       (i_sys_clk),
    .i_rstn          (i_rstn),
    .i_addr          (i_addr),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .i_wdata         (i_wdata),
    .o_rdata         (o_rdata),
    .o_rvalid        (o_rvalid),
    .i_pin_in        (pds_port_bus_t'(pin_bits)),
    .i_cfg           (cfg_v),
    .i_alt_c_entry   (alt_v),
    .o_pin_out       (o_pin_out),
    .o_pin_oe        (o_pin_oe),
    .o_alt_c_set_one (o_alt_c_set_one),
    .o_alt_c_set_two (o_alt_c_set_two)
  );

  //**************************************************************
  // Clock, timeout and helpers
  //**************************************************************
  initial i_sys_clk = 1'b0;
  always #50 i_sys_clk = ~i_sys_clk;

  // Roughly 100 cycles per round; the ceiling leaves a wide margin
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 32'h0000_2710)
    begin
      miscompares++;
      end_of_test();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  function automatic logic [15:0] exp_pin(int p, logic [7:0] drv,
    pds_port_cfg_t c, logic [7:0] s1, logic [7:0] s2, pds_alt_c_t e);
    logic [7:0] o;
    logic [7:0] oe;
    logic       av;
    for (int b = 0; b < 8; b++)
    begin
      av = (p == 2) ? e[{s2[b], s1[b]}][b] : c.alt_val[b];
      o[b] = drv[b];
      oe[b] = 1'b0;
      if (c.alt_en[b])
      begin
        o[b] = av;
        oe[b] = c.alt_oe[b] & ~(c.open_drain[b] & av);
      end
      else if (c.dir_out[b])
        oe[b] = ~(c.open_drain[b] & drv[b]);
    end
    return {o, oe};
  endfunction

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_sys_clk);
    i_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask

  // A read without the valid flag hands back unknowns, which never match
  task automatic rd(logic [11:0] a, output logic [7:0] d);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_sys_clk);
    d = o_rvalid ? o_rdata : 8'hxx;
    i_rd = 1'b0;
    @(negedge i_sys_clk);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  //**************************************************************
  // Main sequence
  //**************************************************************
  initial
  begin
    logic [7:0] d;
    logic [7:0] drv [9];
    logic [7:0] s1;
    logic [7:0] s2;
    lfsr = 16'h0048;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    i_rstn = 1'b0;
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    {pin_bits, cfg_bits, alt_bits} = '0;
    repeat (10) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (int p = 0; p < 9; p++)
    begin
      rd(OUT_A[p], d);
      chk("drive reset", 16'h0000, {d, o_pin_oe[p]});
    end
    for (int it = 0; it < 16; it++)
    begin
      for (int k = 0; k < 45; k++)
        cfg_bits[k*8 +: 8] = rnd();
      for (int k = 0; k < 9; k++)
        pin_bits[k*8 +: 8] = rnd();
      alt_bits = {rnd(), rnd(), rnd(), rnd()};
      s1 = rnd();
      s2 = rnd();
      for (int p = 0; p < 9; p++)
      begin
        drv[p] = (it == 0) ? 8'hff : rnd();
        // Corners: all released, all alternate, all open-drain outputs
        if (it == 0)
          cfg_bits[p*40 +: 40] = '0;
        if (it == 1)
          cfg_bits[p*40 +: 40] = {40{1'b1}};
        if (it == 2)
          cfg_bits[p*40 +: 40] = {16'hffff, 24'h0};
        wr(OUT_A[p], drv[p]);
        wr(IN_A[p], rnd());
      end
      wr(`PDS_C_INDEX, `PDS_SUB_SET_ONE);
      wr(`PDS_C_CONTROL, s1);
      wr(`PDS_C_INDEX, `PDS_SUB_SET_TWO);
      wr(`PDS_C_CONTROL, s2);
      for (int p = 0; p < 9; p++)
      begin
        rd(IN_A[p], d);
        chk("sample", {8'h00, PRES[p] ? pin_bits[p*8 +: 8] : 8'h00},
            {8'h00, d});
        if (PRES[p])
        begin
          rd(OUT_A[p], d);
          chk("drive", {8'h00, drv[p]}, {8'h00, d});
          chk("pin", exp_pin(p, drv[p], cfg_v[p], s1, s2, alt_v),
              {o_pin_out[p], o_pin_oe[p]});
        end
        else
          chk("absent oe", 16'h0000, {8'h00, o_pin_oe[p]});
      end
      rd(`PDS_C_CONTROL, d);
      chk("set two", {s2, s2}, {d, o_alt_c_set_two});
      wr(`PDS_C_INDEX, `PDS_SUB_SET_ONE);
      rd(`PDS_C_CONTROL, d);
      chk("set one", {s1, s1}, {d, o_alt_c_set_one});
      wr(`PDS_C_INDEX, 8'h06);
      wr(`PDS_C_CONTROL, rnd());
      rd(`PDS_C_CONTROL, d);
      chk("other index", 16'h0000, {8'h00, d});
      chk("sets kept", {s1, s2}, {o_alt_c_set_one, o_alt_c_set_two});
      rd(`PDS_C_INDEX, d);
      chk("index", 16'h0006, {8'h00, d});
      wr(12'h000, rnd());
      rd(12'h000, d);
      chk("unmapped", 16'h0000, {8'h00, d});
    end
    // Mid-run reset must clear drive and set registers again
    i_rstn = 1'b0;
    @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (int p = 0; p < 9; p++)
    begin
      rd(OUT_A[p], d);
      chk("drive rerun", 16'h0000, {d, 8'h00});
    end
    chk("sets rerun", 16'h0000, {o_alt_c_set_one, o_alt_c_set_two});
    end_of_test();
  end
endmodule
